/* nand_host_regs.svh */
// Register map, commands and timing constants of the NAND host controller
`ifndef NAND_HOST_REGS_SVH
`define NAND_HOST_REGS_SVH

// ****************************************
// Wishbone register offsets (byte addresses)
// ****************************************
`define ADDR_CTRL        6'h00
`define ADDR_ROW         6'h04
`define ADDR_COL         6'h08
`define ADDR_WDATA       6'h0C
`define ADDR_RDATA       6'h10
`define ADDR_STATUS      6'h14
`define ADDR_COUNT       6'h18

// ****************************************
// Control register fields
// ****************************************
`define CTRL_GO_BIT      8
`define CTRL_WP_BIT      9
`define CTRL_OP_LSB      0
`define CTRL_OP_MSB      3

// ****************************************
// Flash command bytes
// ****************************************
`define CMD_READ_A       8'h00
`define CMD_READ_B       8'h01
`define CMD_READ_C       8'h50
`define CMD_SERIAL_IN    8'h80
`define CMD_PROG_GO      8'h10
`define CMD_ERASE_SETUP  8'h60
`define CMD_ERASE_GO     8'hD0
`define CMD_STATUS       8'h70
`define CMD_ID           8'h90
`define CMD_RESET        8'hFF
`define ID_ADDR          8'h00

// ****************************************
// Status byte fields and page geometry
// ****************************************
`define ST_FAIL_BIT      0
`define ST_READY_BIT     6
`define ST_NWP_BIT       7
`define STATUS_RESET     8'hC0
`define PAGE_BYTES       10'd528
`define MAIN_BYTES       10'd512
`define HALF_BYTES       10'd256

// ****************************************
// Timing (50 MHz core clock, 20 ns)
// ****************************************
`define CLK_NS           20
`define STROBE_NS        60
`define STROBE_CYC       ((`STROBE_NS + `CLK_NS - 1) / `CLK_NS)
`define WB_NS            200
`define WB_CYC           ((`WB_NS + `CLK_NS - 1) / `CLK_NS)

`endif

/* nand_host_pkg.sv */
// Types shared by the NAND host controller
package nand_host_pkg;

    typedef enum logic [3:0] {
        OP_READ_MAIN,
        OP_READ_SPARE,
        OP_PROGRAM,
        OP_ERASE,
        OP_STATUS,
        OP_READ_ID,
        OP_RESET,
        OP_READ_BYTE
    } op_t;

    typedef enum logic [1:0] {
        CYC_CMD,
        CYC_ADDR,
        CYC_WDATA,
        CYC_RDATA
    } cyc_kind_t;

    typedef struct packed {
        logic [5:0]  adr;
        logic [31:0] dat;
        logic [3:0]  sel;
        logic        we;
        logic        cyc;
        logic        stb;
    } wb_req_t;

    typedef struct packed {
        logic [31:0] dat;
        logic        ack;
    } wb_rsp_t;

endpackage : nand_host_pkg

/* nand_bus_cycle.sv */
// One flash bus cycle: command, address, data write or data read strobe
`timescale 1ns/1ps
`include "nand_host_regs.svh"
module nand_bus_cycle #(
    parameter int STROBE_CYC = `STROBE_CYC
) (
    input  wire logic                    clk,
    input  wire logic                    rst_b,
    input  wire logic                    start,
    input  wire nand_host_pkg::cyc_kind_t kind,
    input  wire logic [7:0]              wdata,
    input  wire logic [7:0]              io_in,
    output logic                         done,
    output logic [7:0]                   rdata,
    output logic                         cle,
    output logic                         ale,
    output logic                         we_n,
    output logic                         re_n,
    output logic [7:0]                   io_out,
    output logic                         io_oe
);
    import nand_host_pkg::*;

    typedef enum logic [1:0] {IDLE, LOW, HIGH} ph_t;

    ph_t        ph;
    logic [7:0] cnt;
    cyc_kind_t  k;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ph    <= IDLE;
            cnt   <= 8'h00;
            k     <= CYC_CMD;
            done  <= 1'b0;
            rdata <= 8'h00;
            cle   <= 1'b0;
            ale   <= 1'b0;
            we_n  <= 1'b1;
            re_n  <= 1'b1;
            io_out <= 8'h00;
            io_oe <= 1'b0;
        end else begin
            done <= 1'b0;
            unique case (ph)
                IDLE: begin
                    if (start) begin
                        k      <= kind;
                        cle    <= (kind == CYC_CMD);
                        ale    <= (kind == CYC_ADDR);
                        io_out <= wdata;
                        io_oe  <= (kind != CYC_RDATA);
                        we_n   <= (kind == CYC_RDATA);
                        re_n   <= (kind != CYC_RDATA);
                        cnt    <= 8'(STROBE_CYC);
                        ph     <= LOW;
                    end
                end
                LOW: begin
                    if (cnt > 8'h01) begin
                        cnt <= cnt - 8'h01;
                    end else begin
                        // Data is sampled before the read strobe rises
                        if (k == CYC_RDATA) begin
                            rdata <= io_in;
                        end
                        we_n <= 1'b1;
                        re_n <= 1'b1;
                        cnt  <= 8'(STROBE_CYC);
                        ph   <= HIGH;
                    end
                end
                HIGH: begin
                    // Hold time after the rising strobe before releasing lines
                    if (cnt > 8'h01) begin
                        cnt <= cnt - 8'h01;
                    end else begin
                        cle   <= 1'b0;
                        ale   <= 1'b0;
                        io_oe <= 1'b0;
                        done  <= 1'b1;
                        ph    <= IDLE;
                    end
                end
                default: ph <= IDLE;
            endcase
        end
    end

endmodule : nand_bus_cycle

/* nand_page_command_sequencer.sv */
// Host-side NAND flash controller with a Wishbone register port
// Notes on behaviour
// - Page read is read command plus three address cycles.
// - Host issues a main read command to leave the spare area.
// - Host ends sequential read by releasing chip select, then re-addresses.
// - Program is serial-input, three addresses, data, then confirm.
// - Host does not limit partial programs per page; software counts them.
// - Erase is setup, two block addresses, confirm; A14..A23 select block.
// - Host rewrites a read command after status during random read.
// - Identifier read: command, address zero, then as many read cycles as the count register gives.
`timescale 1ns/1ps
`include "nand_host_regs.svh"
module nand_page_command_sequencer #(
    parameter int STROBE_CYC = `STROBE_CYC,
    parameter int WB_CYC     = `WB_CYC,
    parameter int BUF_DEPTH  = 528
) (
    input  wire logic                  CORE_CLK,
    input  wire logic                  RST_B,
    input  wire nand_host_pkg::wb_req_t WB_REQ,
    output nand_host_pkg::wb_rsp_t     WB_RSP,
    output logic                       CE_N,
    output logic                       CLE,
    output logic                       ALE,
    output logic                       WE_N,
    output logic                       RE_N,
    output logic                       WP_N,
    output logic [7:0]                 IO_OUT,
    output logic                       IO_OE,
    input  wire logic [7:0]            IO_IN,
    input  wire logic                  READY_BUSY_N
);
    import nand_host_pkg::*;

    // ****************************************
    // Sequencer states
    // ****************************************
    typedef enum logic [3:0] {
        S_IDLE, S_CMD, S_ADDR, S_WAIT_WB, S_WAIT_RDY,
        S_DATA, S_CONFIRM, S_STATUS_CMD, S_STATUS_RD, S_DONE
    } st_t;

    st_t         st;
    op_t         op;
    logic [23:0] row;
    logic [7:0]  col;
    logic [9:0]  count;
    logic [9:0]  idx;
    logic [1:0]  addr_n;
    logic [7:0]  wb_cnt;
    logic        busy;
    logic [7:0]  status_byte;
    logic [7:0]  buffer [0:BUF_DEPTH-1];
    logic [9:0]  buf_wr_ptr;
    logic [7:0]  buf_rd;

    logic        cyc_start;
    cyc_kind_t   cyc_kind;
    logic [7:0]  cyc_wdata;
    logic        cyc_done;
    logic [7:0]  cyc_rdata;
    logic        cle_i;
    logic        ale_i;
    logic        we_n_i;
    logic        re_n_i;
    logic [7:0]  io_out_i;
    logic        io_oe_i;
    logic [9:0]  wr_idx;

    assign wr_idx = cyc_done ? idx + 10'h001 : idx;

    nand_bus_cycle #(.STROBE_CYC(STROBE_CYC)) u_cycle (
        .clk    (CORE_CLK),
        .rst_b  (RST_B),
        .start  (cyc_start),
        .kind   (cyc_kind),
        .wdata  (cyc_wdata),
        .io_in  (IO_IN),
        .done   (cyc_done),
        .rdata  (cyc_rdata),
        .cle    (cle_i),
        .ale    (ale_i),
        .we_n   (we_n_i),
        .re_n   (re_n_i),
        .io_out (io_out_i),
        .io_oe  (io_oe_i)
    );

    // ****************************************
    // Pin outputs, registered once more
    // ****************************************
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            CLE    <= 1'b0;
            ALE    <= 1'b0;
            WE_N   <= 1'b1;
            RE_N   <= 1'b1;
            IO_OUT <= 8'h00;
            IO_OE  <= 1'b0;
        end else begin
            CLE    <= cle_i;
            ALE    <= ale_i;
            WE_N   <= we_n_i;
            RE_N   <= re_n_i;
            IO_OUT <= io_out_i;
            IO_OE  <= io_oe_i;
        end
    end

    // ****************************************
    // Wishbone slave, one-cycle ack
    // ****************************************
    logic       wb_hit;
    logic       wb_wr;
    logic       go;
    logic [3:0] go_op;

    assign wb_hit = WB_REQ.cyc && WB_REQ.stb && !WB_RSP.ack;
    assign wb_wr  = wb_hit && WB_REQ.we;
    assign go     = wb_wr && (WB_REQ.adr == `ADDR_CTRL) && WB_REQ.dat[`CTRL_GO_BIT]
                    && (st == S_IDLE);
    assign go_op  = WB_REQ.dat[`CTRL_OP_MSB:`CTRL_OP_LSB];

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            WB_RSP <= '0;
        end else begin
            WB_RSP.ack <= wb_hit;
            WB_RSP.dat <= 32'h0000_0000;
            if (wb_hit && !WB_REQ.we) begin
                unique case (WB_REQ.adr)
                    `ADDR_CTRL:   WB_RSP.dat <= {23'h0, busy, 4'h0, 4'(op)};
                    `ADDR_ROW:    WB_RSP.dat <= {8'h00, row};
                    `ADDR_COL:    WB_RSP.dat <= {24'h0, col};
                    `ADDR_RDATA:  WB_RSP.dat <= {24'h0, buf_rd};
                    `ADDR_STATUS: WB_RSP.dat <= {24'h0, status_byte};
                    `ADDR_COUNT:  WB_RSP.dat <= {22'h0, count};
                    default:      WB_RSP.dat <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ****************************************
    // Software parameter registers
    // ****************************************
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            row   <= 24'h000000;
            col   <= 8'h00;
            count <= 10'h000;
            WP_N  <= 1'b0;
        end else if (wb_wr && st == S_IDLE) begin
            if (WB_REQ.adr == `ADDR_ROW) begin
                row <= WB_REQ.dat[23:0];
            end
            if (WB_REQ.adr == `ADDR_COL) begin
                col <= WB_REQ.dat[7:0];
            end
            if (WB_REQ.adr == `ADDR_COUNT) begin
                count <= WB_REQ.dat[9:0];
            end
            if (WB_REQ.adr == `ADDR_CTRL) begin
                WP_N <= WB_REQ.dat[`CTRL_WP_BIT];
            end
        end
    end

    // ****************************************
    // Page buffer: software fills it, reads fill it too
    // ****************************************
    always_ff @(posedge CORE_CLK) begin
        if (wb_wr && WB_REQ.adr == `ADDR_WDATA && st == S_IDLE) begin
            buffer[buf_wr_ptr] <= WB_REQ.dat[7:0];
        end else if (st == S_DATA && cyc_done && op != OP_PROGRAM) begin
            buffer[idx] <= cyc_rdata;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            buf_wr_ptr <= 10'h000;
            buf_rd     <= 8'h00;
        end else begin
            if (go) begin
                buf_wr_ptr <= 10'h000;
            end else if (wb_wr && WB_REQ.adr == `ADDR_WDATA && st == S_IDLE
                         && buf_wr_ptr < 10'(BUF_DEPTH - 1)) begin
                buf_wr_ptr <= buf_wr_ptr + 10'h001;
            end
            buf_rd <= buffer[count < 10'(BUF_DEPTH) ? count : 10'h000];
        end
    end

    // ****************************************
    // Operation sequencer
    // ****************************************
    function automatic logic [7:0] first_cmd(input op_t o, input logic [7:0] c);
        unique case (o)
            OP_READ_SPARE: first_cmd = `CMD_READ_C;
            OP_PROGRAM:    first_cmd = `CMD_SERIAL_IN;
            OP_ERASE:      first_cmd = `CMD_ERASE_SETUP;
            OP_STATUS:     first_cmd = `CMD_STATUS;
            OP_READ_ID:    first_cmd = `CMD_ID;
            OP_RESET:      first_cmd = `CMD_RESET;
            default:       first_cmd = `CMD_READ_A;
        endcase
    endfunction : first_cmd

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            st          <= S_IDLE;
            op          <= OP_READ_MAIN;
            CE_N        <= 1'b1;
            cyc_start   <= 1'b0;
            cyc_kind    <= CYC_CMD;
            cyc_wdata   <= 8'h00;
            idx         <= 10'h000;
            addr_n      <= 2'd0;
            wb_cnt      <= 8'h00;
            busy        <= 1'b0;
            status_byte <= `STATUS_RESET;
        end else begin
            cyc_start <= 1'b0;
            unique case (st)
                S_IDLE: begin
                    if (go) begin
                        op   <= op_t'(go_op);
                        busy <= 1'b1;
                        CE_N <= 1'b0;
                        idx  <= 10'h000;
                        st   <= S_CMD;
                    end
                end
                S_CMD: begin
                    // a command opens every page read except OP_READ_BYTE, which goes straight to S_DATA
                    // main read command returns pointer from spare
                    cyc_kind  <= CYC_CMD;
                    cyc_wdata <= first_cmd(op, col);
                    cyc_start <= (op != OP_READ_BYTE);
                    addr_n    <= 2'd0;
                    st        <= (op == OP_READ_BYTE) ? S_DATA : S_ADDR;
                end
                S_ADDR: begin
                    if (cyc_done) begin
                        if (op == OP_STATUS || op == OP_RESET) begin
                            wb_cnt <= 8'(WB_CYC);
                            st     <= S_WAIT_WB;
                        end else if ((op == OP_READ_ID && addr_n == 2'd1)
                                     || (op == OP_ERASE && addr_n == 2'd2)
                                     || addr_n == 2'd3) begin
                            // erase confirm after two block addresses
                            if (op == OP_ERASE) begin
                                cyc_kind  <= CYC_CMD;
                                cyc_wdata <= `CMD_ERASE_GO;
                                cyc_start <= 1'b1;
                                st        <= S_CONFIRM;
                            end else if (op == OP_PROGRAM) begin
                                st <= S_DATA;
                            end else begin
                                wb_cnt <= 8'(WB_CYC);
                                st     <= S_WAIT_WB;
                            end
                        end else if (!cyc_start) begin
                            cyc_kind  <= CYC_ADDR;
                            cyc_wdata <= (op == OP_READ_ID) ? `ID_ADDR :
                                         (op == OP_ERASE) ?
                                             (addr_n == 2'd0 ? row[7:0] : row[15:8]) :
                                         (addr_n == 2'd0) ? col :
                                         (addr_n == 2'd1) ? row[7:0] : row[15:8];
                            cyc_start <= 1'b1;
                            addr_n    <= addr_n + 2'd1;
                        end
                    end
                end
                S_WAIT_WB: begin
                    // Ready/busy needs time to fall after the last strobe
                    if (wb_cnt > 8'h01) begin
                        wb_cnt <= wb_cnt - 8'h01;
                    end else begin
                        st <= S_WAIT_RDY;
                    end
                end
                S_WAIT_RDY: begin
                    // wait for page load, program, erase or reset to finish
                    // open-drain ready/busy high ends the wait
                    if (READY_BUSY_N) begin
                        if (op == OP_PROGRAM || op == OP_ERASE) begin
                            st <= S_STATUS_CMD;
                        end else if (op == OP_RESET) begin
                            status_byte <= `STATUS_RESET;
                            st          <= S_DONE;
                        end else begin
                            st <= S_DATA;
                        end
                    end
                end
                S_DATA: begin
                    // one read or write strobe per byte, next column each time
                    // status reads repeat without a new command
                    if (cyc_done) begin
                        idx <= idx + 10'h001;
                    end
                    if (cyc_done && idx + 10'h001 >= count) begin
                        if (op == OP_PROGRAM) begin
                            cyc_kind  <= CYC_CMD;
                            cyc_wdata <= `CMD_PROG_GO;
                            cyc_start <= 1'b1;
                            st        <= S_CONFIRM;
                        end else begin
                            if (op == OP_STATUS) begin
                                status_byte <= cyc_rdata;
                            end
                            st <= S_DONE;
                        end
                    end else if (count == 10'h000) begin
                        st <= S_DONE;
                    end else if (!cyc_start && (idx == 10'h000 || cyc_done)) begin
                        cyc_kind  <= (op == OP_PROGRAM) ? CYC_WDATA : CYC_RDATA;
                        // idx still names the byte just sent
                        cyc_wdata <= buffer[wr_idx < 10'(BUF_DEPTH) ? wr_idx : 10'h000];
                        cyc_start <= (cyc_done || idx == 10'h000);
                    end
                end
                S_CONFIRM: begin
                    // one program per order; software counts partials
                    if (cyc_done) begin
                        wb_cnt <= 8'(WB_CYC);
                        st     <= S_WAIT_WB;
                    end
                end
                S_STATUS_CMD: begin
                    // only status read is issued while busy-bound
                    // status byte latched; software checks its fail bit
                    cyc_kind  <= CYC_CMD;
                    cyc_wdata <= `CMD_STATUS;
                    cyc_start <= 1'b1;
                    st        <= S_STATUS_RD;
                end
                S_STATUS_RD: begin
                    if (cyc_done && cyc_kind == CYC_CMD) begin
                        cyc_kind  <= CYC_RDATA;
                        cyc_start <= 1'b1;
                    end else if (cyc_done) begin
                        status_byte <= cyc_rdata;
                        st          <= S_DONE;
                    end
                end
                S_DONE: begin
                    // chip select released to end any sequential read
                    // busy flag follows the sequence end
                    CE_N <= 1'b1;
                    busy <= 1'b0;
                    st   <= S_IDLE;
                end
                default: st <= S_IDLE;
            endcase
        end
    end

endmodule : nand_page_command_sequencer

/* nand_host_sva.sv */
// Pin and bus assertions of the NAND host controller
`timescale 1ns/1ps
module nand_host_sva (
    input wire logic                   CORE_CLK,
    input wire logic                   RST_B,
    input wire nand_host_pkg::wb_req_t WB_REQ,
    input wire nand_host_pkg::wb_rsp_t WB_RSP,
    input wire logic                   CE_N,
    input wire logic                   CLE,
    input wire logic                   ALE,
    input wire logic                   WE_N,
    input wire logic                   RE_N,
    input wire logic                   IO_OE
);
    import nand_host_pkg::*;
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_B);
    bus_answer_a: assert property (WB_REQ.cyc && WB_REQ.stb && !WB_RSP.ack |=> WB_RSP.ack)
        else $error("ack missing");
    ack_pulse_a: assert property (WB_RSP.ack |=> !WB_RSP.ack) else $error("ack held");
    latch_excl_a: assert property (!(CLE && ALE)) else $error("cle with ale");
    latch_sel_a: assert property (CLE || ALE |-> !CE_N) else $error("latch unselected");
    strobe_excl_a: assert property (!(!WE_N && !RE_N)) else $error("both strobes");
    read_float_a: assert property (!RE_N |-> !IO_OE) else $error("drive on read");
    write_drive_a: assert property (!WE_N |-> IO_OE) else $error("write undriven");
    we_width_a: assert property ($fell(WE_N) |-> !WE_N [*3] ##1 WE_N)
        else $error("write strobe width");
    cover property ($fell(CLE));
    cover property ($rose(ALE));
    cover property ($fell(RE_N));
endmodule : nand_host_sva
bind nand_page_command_sequencer nand_host_sva u_sva (.CORE_CLK, .RST_B, .WB_REQ, .WB_RSP,
    .CE_N, .CLE, .ALE, .WE_N, .RE_N, .IO_OE);

/* nand_flash_model.sv */
// Behavioural NAND flash device facing the host controller
`timescale 1ns/1ps
module nand_flash_model #(
    parameter logic [7:0] MFR = 8'h3C, // Arbitrary value
    parameter logic [7:0] DEV = 8'h5A  // Arbitrary value
) (
    input wire logic       ce_n,
    input wire logic       cle,
    input wire logic       ale,
    input wire logic       we_n,
    input wire logic       re_n,
    input wire logic       wp_n,
    input wire logic [7:0] din,
    output logic [7:0]     dout,
    output logic           rb_n
);
    logic [7:0] mem [0:527];
    logic [7:0] cmd = 8'h00;
    logic       spr = 1'b0, prg = 1'b0;
    int         col = 0, na = 0, bt = 0;
    initial for (int i = 0; i < 528; i++) mem[i] = 8'(i) ^ 8'hA5;
    initial dout = 8'h00;
    always #20 if (bt > 0) bt--;
    assign rb_n = (bt == 0);
    always @(posedge we_n) if (!ce_n && cle && (bt == 0 || din inside {8'h70, 8'hFF})) begin
        if (din == 8'h10 && prg) bt = 200;
        if (din == 8'hD0 && cmd == 8'h60) begin
            bt = 500;
            for (int i = 0; i < 528; i++) mem[i] = 8'hFF;
        end
        if (din == 8'hFF && !(cmd == 8'hFF && bt > 0)) bt = 25;
        prg = (din == 8'h80);
        spr = (din == 8'h50) || (spr && !(din inside {8'h00, 8'h01}));
        cmd = din;
        na = 0;
    end else if (!ce_n && ale) begin
        if (na == 0) col = spr ? 512 + din[3:0] : din + (cmd == 8'h01 ? 256 : 0);
        na++;
        if (na == 3 && cmd inside {8'h00, 8'h01, 8'h50}) bt = 50;
        if (na == 3 && cmd == 8'h01) cmd = 8'h00;
    end else if (!ce_n && cmd == 8'h80) begin
        mem[col] = mem[col] & din;
        col++;
    end
    always @(negedge re_n) if (!ce_n) begin
        if (cmd == 8'h70) dout = {wp_n, rb_n, 6'h00};
        else if (cmd == 8'h90) dout = (col == 0) ? MFR : DEV;
        else dout = mem[col];
        col++;
        // last column wraps to column zero of the one page array, with a busy time
        if (col == 528) begin col = 0; bt = 50; end
    end
    // Released port shows the inverse so stale data cannot match
    always @(posedge re_n) #10 dout = ~dout;
endmodule : nand_flash_model

/* nand_page_command_sequencer_tb_top.sv */
// Self-checking bench of the NAND host controller
`timescale 1ns/1ps
`include "nand_host_regs.svh"
`define CHECK(g, e) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
    $display("BAD %0t got %h exp %h", $time, g, e); end end
module nand_page_command_sequencer_tb_top;
    import nand_host_pkg::*;
    logic        clk = 1'b0, rst_b = 1'b0;
    wb_req_t     req = '0;
    wb_rsp_t     rsp;
    logic        ce_n, cle, ale, we_n, re_n, wp_n, oe, rb_n;
    logic [7:0]  io_out, f_out, io;
    logic [7:0]  img [0:527];
    logic [31:0] q;
    int          error_cnt = 0, n_compared = 0;
    always #10 clk = ~clk;
    assign io = oe ? io_out : f_out;
    nand_page_command_sequencer DUT (.CORE_CLK(clk), .RST_B(rst_b), .WB_REQ(req), .WB_RSP(rsp),
        .CE_N(ce_n), .CLE(cle), .ALE(ale), .WE_N(we_n), .RE_N(re_n), .WP_N(wp_n),
        .IO_OUT(io_out), .IO_OE(oe), .IO_IN(io), .READY_BUSY_N(rb_n));
    nand_flash_model FLASH (.ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n), .re_n(re_n),
        .wp_n(wp_n), .din(io), .dout(f_out), .rb_n(rb_n));
    task automatic bus(input logic [5:0] a, input logic w, input logic [31:0] d);
        int t;
        req <= '{adr: a, dat: d, sel: 4'hF, we: w, cyc: 1'b1, stb: 1'b1};
        @(posedge clk);
        for (t = 1; rsp.ack !== 1'b1 && t < 50; t++) @(posedge clk);
        q = rsp.dat;
        req <= '0;
        @(posedge clk);
        if (t == 50) error_cnt++;
    endtask : bus
    task automatic rdat(input logic [5:0] a, input int i, input logic [31:0] e);
        if (i >= 0) bus(`ADDR_COUNT, 1'b1, i);
        bus(a, 1'b0, 32'h0);
        `CHECK(q, e)
    endtask : rdat
    task automatic op(input logic [3:0] o, input logic wp = 1'b1);
        int k = 0;
        bus(`ADDR_CTRL, 1'b1, {22'h0, wp, 1'b1, 4'h0, o});
        do bus(`ADDR_CTRL, 1'b0, 32'h0); while (q[8] !== 1'b0 && ++k < 2000);
        if (q[8] !== 1'b0) error_cnt++;
    endtask : op
    task automatic rdbuf(input logic [3:0] o, input logic [7:0] c, input int s);
        bus(`ADDR_COL, 1'b1, {24'h0, c});
        bus(`ADDR_COUNT, 1'b1, 32'h4);
        op(o);
        for (int i = 0; i < 4; i++) rdat(`ADDR_RDATA, i, {24'h0, img[s + i]});
    endtask : rdbuf
    task automatic test_done;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : test_done
    initial begin
        repeat (60000) @(posedge clk);
        error_cnt++;
        test_done;
    end
    initial begin
        for (int i = 0; i < 528; i++) img[i] = 8'(i) ^ 8'hA5;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        rdat(`ADDR_STATUS, -1, 32'hC0);
        rdat(6'h3C, -1, 32'h0);
        bus(`ADDR_ROW, 1'b1, 32'h0);
        bus(`ADDR_COUNT, 1'b1, 32'h1);
        op(4, 1'b0);
        rdat(`ADDR_STATUS, -1, 32'h40);
        rdbuf(0, 8'h05, 5);
        rdbuf(1, 8'h33, 515);
        rdbuf(0, 8'hFE, 254);
        bus(`ADDR_COUNT, 1'b1, 32'h2);
        op(7);
        for (int i = 0; i < 2; i++) rdat(`ADDR_RDATA, i, {24'h0, img[258 + i]});
        bus(`ADDR_COL, 1'b1, 32'h0);
        bus(`ADDR_COUNT, 1'b1, 32'h2);
        bus(`ADDR_WDATA, 1'b1, 32'h0F);
        bus(`ADDR_WDATA, 1'b1, 32'hF0);
        op(2);
        img[0] &= 8'h0F;
        img[1] &= 8'hF0;
        rdat(`ADDR_STATUS, -1, 32'hC0);
        rdbuf(0, 8'h00, 0);
        bus(`ADDR_COUNT, 1'b1, 32'h2);
        op(5);
        rdat(`ADDR_RDATA, 0, 32'h3C);
        rdat(`ADDR_RDATA, 1, 32'h5A);
        op(3);
        for (int i = 0; i < 528; i++) img[i] = 8'hFF;
        rdat(`ADDR_STATUS, -1, 32'hC0);
        rdbuf(0, 8'h00, 0);
        op(6);
        rdat(`ADDR_STATUS, -1, 32'hC0);
        test_done;
    end
endmodule : nand_page_command_sequencer_tb_top
